// ---- src/sil_pkg.sv ----
// Purpose: Shared constants and types of the status input logger channel
// Assumes: 40 MHz system clock, APB register access
// Notes:   Offsets are byte addresses of 32-bit words
`default_nettype none
package sil_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_PERIOD = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_DATA   = 8'h0c;
  localparam logic [7:0] ADDR_TRIG   = 8'h10;
  localparam logic [7:0] ADDR_THR_A  = 8'h14;
  localparam logic [7:0] ADDR_THR_B  = 8'h18;
  localparam logic [7:0] ADDR_HYST   = 8'h1c;

  // Control register fields
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_PIN_BIT  = 1;
  localparam int CTRL_UNIT_BIT = 2;
  localparam int CTRL_MODE_LSB = 4;

  // Trigger register fields
  localparam int TRIG_EN_BIT   = 0;
  localparam int TRIG_KIND_LSB = 4;
  localparam int TRIG_C_LSB    = 8;
  localparam int TRIG_D_LSB    = 12;

  // Status register fields
  localparam int STAT_RAW_BIT  = 0;
  localparam int STAT_TRIG_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_CNT_LSB  = 16;

  // Reset values
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [15:0] PERIOD_RST = 16'h0384;
  localparam logic [31:0] TRIG_RST   = 32'h0000_1100;
  localparam logic [15:0] THR_RST    = 16'h0000;

  // Data scaling
  localparam logic [15:0] FRAC_FULL  = 16'h2710;
  localparam int          DIV_STEPS  = 30;
  localparam int          HIST_MAX   = 8;

  // Timebase
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned SEC_TIME_S  = 1;
  localparam int unsigned CYC_PER_SEC = CLK_HZ * SEC_TIME_S;

  typedef enum logic [1:0] {
    MODE_SPOT     = 2'b00,
    MODE_SPOT_INV = 2'b01,
    MODE_CLOSED   = 2'b10,
    MODE_OPEN     = 2'b11
  } sil_mode_t;

  typedef enum logic [1:0] {
    TRIG_ABOVE   = 2'b00,
    TRIG_BELOW   = 2'b01,
    TRIG_BETWEEN = 2'b10
  } sil_trig_t;

endpackage : sil_pkg
`default_nettype wire

// ---- src/sil_timebase.sv ----
// Purpose: One-second tick and log-period boundary pulses
// Assumes: CYC_PER_SEC of at least 64
// Notes:   Log boundary pulse coincides with the last second tick of a period
`timescale 1ns/1ps
`default_nettype none
module sil_timebase #(
  parameter int unsigned CYC_PER_SEC = sil_pkg::CYC_PER_SEC
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // Control
  input  wire logic        run,
  input  wire logic [15:0] period,
  // Ticks
  output logic             sec_tick,
  output logic             log_tick
);

  localparam int unsigned DW = $clog2(CYC_PER_SEC);

  logic [DW-1:0] div_q;
  logic [15:0]   sec_q;
  logic          wrap;

  assign wrap = (div_q == DW'(CYC_PER_SEC - 1));

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_q    <= '0;
      sec_tick <= 1'b0;
    end else if (!run) begin
      div_q    <= '0;
      sec_tick <= 1'b0;
    end else begin
      div_q    <= wrap ? '0 : div_q + 1'b1;
      sec_tick <= wrap;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sec_q    <= '0;
      log_tick <= 1'b0;
    end else if (!run) begin
      sec_q    <= '0;
      log_tick <= 1'b0;
    end else if (wrap && sec_q >= period - 16'h0001) begin
      sec_q    <= '0;
      log_tick <= 1'b1;
    end else begin
      sec_q    <= wrap ? sec_q + 16'h0001 : sec_q;
      log_tick <= 1'b0;
    end
  end

endmodule : sil_timebase
`default_nettype wire

// ---- src/sil_trigger.sv ----
// Purpose: Threshold trigger over the last D logged datapoints
// Assumes: One dp_valid pulse per log boundary
// Notes:   Hysteresis widens the band only while the trigger is active
`timescale 1ns/1ps
`default_nettype none
module sil_trigger #(
  parameter int HIST = sil_pkg::HIST_MAX
) (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_b,
  // Configuration
  input  wire logic               enable,
  input  wire logic [1:0]         kind,
  input  wire logic [3:0]         c_need,
  input  wire logic [3:0]         d_win,
  input  wire logic signed [15:0] thr_a,
  input  wire logic signed [15:0] thr_b,
  input  wire logic signed [15:0] hyst,
  // Datapoints
  input  wire logic               dp_valid,
  input  wire logic [15:0]        dp_value,
  // Result
  output logic                    active
);

  logic [HIST-1:0] hist_q;
  logic [HIST-1:0] hist_d;
  logic            sample;
  logic [3:0]      d_eff;
  logic [3:0]      c_eff;
  logic [3:0]      hits;

  function automatic logic meets(input logic [1:0] k, input logic signed [17:0] v,
                                 input logic signed [17:0] a, input logic signed [17:0] b,
                                 input logic signed [17:0] h, input logic held);
    logic signed [17:0] lo;
    logic signed [17:0] hi;
    lo = held ? a - h : a;
    hi = held ? b + h : b;
    case (k)
      sil_pkg::TRIG_ABOVE:   meets = held ? (v >= lo) : (v > a);
      sil_pkg::TRIG_BELOW:   meets = held ? (v <= a + h) : (v < a);
      sil_pkg::TRIG_BETWEEN: meets = (v >= lo) && (v <= hi);
      default:               meets = 1'b0;
    endcase
  endfunction : meets

  function automatic logic [3:0] count_win(input logic [HIST-1:0] h, input logic [3:0] d);
    logic [3:0] n;
    n = '0;
    for (int i = 0; i < HIST; i++) begin
      if (h[i] && (4'(i) < d)) n = n + 4'h1;
    end
    count_win = n;
  endfunction : count_win

  // Hold band applies while active, so clearing needs a move past it [RULE22]
  assign sample = meets(kind, {2'b00, dp_value}, 18'(thr_a), 18'(thr_b), 18'(hyst),
                        active); // [RULE12] [RULE14] [RULE15] [RULE16] [RULE17] [RULE19]
  assign hist_d = {hist_q[HIST-2:0], sample};
  assign d_eff  = (d_win == 4'h0) ? 4'h1 : (d_win > 4'(HIST)) ? 4'(HIST) : d_win;
  assign c_eff  = (c_need == 4'h0) ? 4'h1 : c_need;
  assign hits   = count_win(hist_d, d_eff);

  // Evaluated only at log boundaries on the stored datapoints [RULE11]
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hist_q <= '0;
      active <= 1'b0;
    end else if (!enable) begin
      hist_q <= '0;
      active <= 1'b0;
    end else if (dp_valid) begin
      hist_q <= hist_d;
      active <= (hits >= c_eff); // [RULE13]
    end
  end

endmodule : sil_trigger
`default_nettype wire

// ---- src/sil_top.sv ----
// Purpose: Status input logger channel with APB registers
// Assumes: Switch pins synchronous to clk_sys, closed contact reads high
// Notes:   One datapoint per log period, one trigger evaluated per datapoint
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE1: Status unit logs each datapoint as binary 0 or 1.
// RULE2: Snapshot mode logs the current input level at each log boundary.
// RULE3: Inverted snapshot logs the complement of the sampled level.
// RULE4: Hardware test read returns the raw pin level before inversion.
// RULE5: Seconds unit logs seconds spent at level one between datapoints.
// RULE6: The seconds counter clears each time a datapoint is produced.
// RULE7: A seconds datapoint never exceeds the seconds in the log period.
// RULE8: Fraction modes scale time in the chosen condition to 0..10000.
// RULE9: Closed fraction: zero means always open, 10000 means always closed.
// RULE10: Open fraction mode measures the share of time the input is open.
// RULE11: Triggers evaluate at log boundaries on the stored datapoints.
// RULE12: Above-zero trigger on binary data fires when log goes 0 to 1.
// RULE13: A trigger asserts when its condition holds for C of last D.
// RULE14: Window trigger fires when datapoint lies between A and B.
// RULE15: Below trigger fires when the datapoint is less than A.
// RULE16: Above-one trigger never fires on binary data.
// RULE17: Below trigger with threshold zero or less never fires on fractions.
// RULE18: Status use selects one pin of the pulse input pair.
// RULE19: Below threshold above the data range keeps the trigger asserted.
// RULE20: Closed contact is level one, open contact is level zero.
// RULE21: Input is sampled on a one-second tick feeding counts and fractions.
// RULE22: A trigger clears only once the datapoint passes the hysteresis band.
module sil_top #(
  parameter int unsigned CYC_PER_SEC = sil_pkg::CYC_PER_SEC
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Switch contact pair
  input  wire logic [1:0]  pulse_pin,
  // Logged data and trigger
  output logic             log_strobe,
  output logic      [15:0] log_data,
  output logic             trig_active
);

  // Datapoint sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIV  = 2'b01,
    ST_POST = 2'b10
  } sil_state_t;

  // Configuration registers
  logic               ctrl_en_q;
  logic               ctrl_pin_q;
  logic               ctrl_unit_q;
  sil_pkg::sil_mode_t ctrl_mode_q;
  logic [15:0]        period_q;
  logic               trig_en_q;
  logic [1:0]         trig_kind_q;
  logic [3:0]         trig_c_q;
  logic [3:0]         trig_d_q;
  logic signed [15:0] thr_a_q;
  logic signed [15:0] thr_b_q;
  logic signed [15:0] hyst_q;

  // Datapath state
  sil_state_t         state_q;
  logic               raw_q;
  logic [15:0]        cnt_q;
  logic [15:0]        value_q;
  logic [29:0]        dvd_q;
  logic [15:0]        rem_q;
  logic [4:0]         step_q;

  // Combinational
  logic               acc;
  logic               wr;
  logic [15:0]        per_eff;
  logic               lvl_post;
  logic               hit;
  logic [16:0]        sum;
  logic [15:0]        total;
  logic [16:0]        trial;
  logic               fits;
  logic               sec_tick;
  logic               log_tick;

  // Register map decode, shared by the write strobe and error paths
  function automatic logic mapped(input logic [7:0] a);
    case (a)
      sil_pkg::ADDR_CTRL,
      sil_pkg::ADDR_PERIOD,
      sil_pkg::ADDR_STATUS,
      sil_pkg::ADDR_DATA,
      sil_pkg::ADDR_TRIG,
      sil_pkg::ADDR_THR_A,
      sil_pkg::ADDR_THR_B,
      sil_pkg::ADDR_HYST: mapped = 1'b1;
      default:            mapped = 1'b0;
    endcase
  endfunction : mapped

  // Transfer completes when the access cycle is answered
  assign acc     = psel & penable & pready;
  assign wr      = acc & pwrite & mapped(paddr);
  // A zero period would put the boundary 65536 seconds apart, so it counts as one second
  assign per_eff = (period_q == 16'h0000) ? 16'h0001 : period_q;

  // Register file writes
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_en_q   <= sil_pkg::CTRL_RST[sil_pkg::CTRL_EN_BIT];
      ctrl_pin_q  <= sil_pkg::CTRL_RST[sil_pkg::CTRL_PIN_BIT];
      ctrl_unit_q <= sil_pkg::CTRL_RST[sil_pkg::CTRL_UNIT_BIT];
      ctrl_mode_q <= sil_pkg::sil_mode_t'(sil_pkg::CTRL_RST[sil_pkg::CTRL_MODE_LSB +: 2]);
      period_q    <= sil_pkg::PERIOD_RST;
    end else if (wr && paddr == sil_pkg::ADDR_CTRL) begin
      ctrl_en_q   <= pwdata[sil_pkg::CTRL_EN_BIT];
      ctrl_pin_q  <= pwdata[sil_pkg::CTRL_PIN_BIT];
      ctrl_unit_q <= pwdata[sil_pkg::CTRL_UNIT_BIT];
      ctrl_mode_q <= sil_pkg::sil_mode_t'(pwdata[sil_pkg::CTRL_MODE_LSB +: 2]);
    end else if (wr && paddr == sil_pkg::ADDR_PERIOD) begin
      period_q    <= pwdata[15:0];
    end
  end

  // Trigger configuration writes
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      trig_en_q   <= sil_pkg::TRIG_RST[sil_pkg::TRIG_EN_BIT];
      trig_kind_q <= sil_pkg::TRIG_RST[sil_pkg::TRIG_KIND_LSB +: 2];
      trig_c_q    <= sil_pkg::TRIG_RST[sil_pkg::TRIG_C_LSB +: 4];
      trig_d_q    <= sil_pkg::TRIG_RST[sil_pkg::TRIG_D_LSB +: 4];
      thr_a_q     <= sil_pkg::THR_RST;
      thr_b_q     <= sil_pkg::THR_RST;
      hyst_q      <= sil_pkg::THR_RST;
    end else if (wr) begin
      case (paddr)
        sil_pkg::ADDR_TRIG: begin
          trig_en_q   <= pwdata[sil_pkg::TRIG_EN_BIT];
          trig_kind_q <= pwdata[sil_pkg::TRIG_KIND_LSB +: 2];
          trig_c_q    <= pwdata[sil_pkg::TRIG_C_LSB +: 4];
          trig_d_q    <= pwdata[sil_pkg::TRIG_D_LSB +: 4];
        end
        sil_pkg::ADDR_THR_A: thr_a_q <= pwdata[15:0];
        sil_pkg::ADDR_THR_B: thr_b_q <= pwdata[15:0];
        sil_pkg::ADDR_HYST:  hyst_q  <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // APB answer: one wait-free access cycle after each setup cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel & ~penable & ~pready;
      if (psel && !penable) begin
        case (paddr)
          sil_pkg::ADDR_CTRL: begin
            prdata <= '0;
            prdata[sil_pkg::CTRL_EN_BIT]        <= ctrl_en_q;
            prdata[sil_pkg::CTRL_PIN_BIT]       <= ctrl_pin_q;
            prdata[sil_pkg::CTRL_UNIT_BIT]      <= ctrl_unit_q;
            prdata[sil_pkg::CTRL_MODE_LSB +: 2] <= ctrl_mode_q;
          end
          sil_pkg::ADDR_PERIOD: prdata <= {16'h0000, period_q};
          sil_pkg::ADDR_STATUS: begin
            prdata <= '0;
            prdata[sil_pkg::STAT_RAW_BIT]       <= raw_q; // [RULE4]
            prdata[sil_pkg::STAT_TRIG_BIT]      <= trig_active;
            prdata[sil_pkg::STAT_BUSY_BIT]      <= (state_q != ST_IDLE);
            prdata[sil_pkg::STAT_CNT_LSB +: 16] <= cnt_q;
          end
          sil_pkg::ADDR_DATA: prdata <= {16'h0000, log_data};
          sil_pkg::ADDR_TRIG: begin
            prdata <= '0;
            prdata[sil_pkg::TRIG_EN_BIT]        <= trig_en_q;
            prdata[sil_pkg::TRIG_KIND_LSB +: 2] <= trig_kind_q;
            prdata[sil_pkg::TRIG_C_LSB +: 4]    <= trig_c_q;
            prdata[sil_pkg::TRIG_D_LSB +: 4]    <= trig_d_q;
          end
          sil_pkg::ADDR_THR_A: prdata <= {16'h0000, thr_a_q};
          sil_pkg::ADDR_THR_B: prdata <= {16'h0000, thr_b_q};
          sil_pkg::ADDR_HYST:  prdata <= {16'h0000, hyst_q};
          default:             prdata <= '0;
        endcase
      end
    end
  end

  // Error answer stands in the access cycle only, then drops
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel & ~penable & ~mapped(paddr);
    end
  end

  // Selected pin of the pair, closed contact reads high
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      raw_q <= 1'b0;
    end else begin
      raw_q <= pulse_pin[ctrl_pin_q]; // [RULE18] [RULE20]
    end
  end

  // Post-inversion level, what spot modes log and triggers see
  assign lvl_post = raw_q ^ (ctrl_mode_q == sil_pkg::MODE_SPOT_INV); // [RULE3]

  // Condition counted per second
  always_comb begin
    case (ctrl_mode_q)
      sil_pkg::MODE_CLOSED: hit = raw_q;   // [RULE9]
      sil_pkg::MODE_OPEN:   hit = ~raw_q;  // [RULE10]
      default:              hit = lvl_post;
    endcase
  end

  sil_timebase #(
    .CYC_PER_SEC (CYC_PER_SEC)
  ) u_timebase (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .run      (ctrl_en_q),
    .period   (per_eff),
    .sec_tick (sec_tick),
    .log_tick (log_tick)
  );

  // Seconds in condition, including the sample of the closing tick
  assign sum   = {1'b0, cnt_q} + {16'h0000, hit};
  assign total = (sum > {1'b0, per_eff}) ? per_eff : sum[15:0]; // [RULE7]

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else if (!ctrl_en_q || log_tick) begin
      cnt_q <= '0; // [RULE6]
    end else if (sec_tick && hit && cnt_q < per_eff) begin
      cnt_q <= cnt_q + 16'h0001; // [RULE5] [RULE21]
    end
  end

  // Restoring division step for the fraction scaling
  assign trial = {rem_q, dvd_q[29]};
  assign fits  = (trial >= {1'b0, per_eff});

  // Datapoint sequencer: capture at the boundary, divide if needed, publish
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      value_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (ctrl_en_q && log_tick) begin
            if (ctrl_unit_q) begin
              value_q <= total; // [RULE5]
              state_q <= ST_POST;
            end else if (!ctrl_mode_q[1]) begin
              value_q <= {15'h0000, lvl_post}; // [RULE1] [RULE2]
              state_q <= ST_POST;
            end else begin
              state_q <= ST_DIV;
            end
          end
        end
        ST_DIV: begin
          if (step_q == 5'h00) begin
            // Last quotient bit comes straight from this step's compare
            value_q <= {dvd_q[14:0], fits}; // [RULE8]
            state_q <= ST_POST;
          end
        end
        ST_POST: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Divider reloads while idle, so it holds the boundary total on entry
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dvd_q  <= '0;
      rem_q  <= '0;
      step_q <= '0;
    end else if (state_q == ST_IDLE) begin
      dvd_q  <= 30'(total) * 30'(sil_pkg::FRAC_FULL); // [RULE8]
      rem_q  <= '0;
      step_q <= 5'(sil_pkg::DIV_STEPS - 1);
    end else if (state_q == ST_DIV) begin
      rem_q  <= fits ? 16'(trial - {1'b0, per_eff}) : trial[15:0];
      dvd_q  <= {dvd_q[28:0], fits};
      step_q <= step_q - 5'h01;
    end
  end

  // Datapoint output
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      log_strobe <= 1'b0;
      log_data   <= '0;
    end else begin
      log_strobe <= (state_q == ST_POST);
      if (state_q == ST_POST) begin
        log_data <= value_q;
      end
    end
  end

  // Trigger sees each datapoint in the cycle it is published
  sil_trigger #(
    .HIST (sil_pkg::HIST_MAX)
  ) u_trigger (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .enable   (trig_en_q),
    .kind     (trig_kind_q),
    .c_need   (trig_c_q),
    .d_win    (trig_d_q),
    .thr_a    (thr_a_q),
    .thr_b    (thr_b_q),
    .hyst     (hyst_q),
    .dp_valid (log_strobe), // [RULE11]
    .dp_value (log_data),
    .active   (trig_active)
  );

endmodule : sil_top
`default_nettype wire

// ---- testbench/sil_switch_model.sv ----
// Purpose: Switch contact pair seen by the logger channel
// Assumes: Closed contact reads high, open reads low
// Notes:   Unselected pin shows the opposite level so a wrong pick shows
`timescale 1ns/1ps
`default_nettype none
module sil_switch_model (
  // Contact state
  input  wire logic       closed,
  input  wire logic       sel,
  // Pin pair
  output logic      [1:0] pulse_pin
);
  always_comb begin
    pulse_pin[sel]  = closed;
    pulse_pin[!sel] = !closed;
  end
endmodule : sil_switch_model
`default_nettype wire

// ---- testbench/sil_top_monitor.sv ----
// Purpose: Port checker of the logger channel top
// Assumes: Zero wait state APB slave
// Notes:   Bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module sil_top_monitor (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_b,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Data
  input wire logic        log_strobe,
  input wire logic [15:0] log_data,
  input wire logic        trig_active
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  chk_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access cycle");
  chk_ready_zero_wait: assert property (psel && !penable |=> pready)
    else $error("pready missing in first access cycle");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response carries data");
  chk_strobe_gap: assert property (log_strobe |=> !log_strobe [*8])
    else $error("datapoints too close");
  chk_data_hold: assert property ($changed(log_data) |-> log_strobe)
    else $error("log data moved without strobe");
  chk_frac_range: assert property (log_strobe |-> log_data <= 16'h2710)
    else $error("datapoint above full scale");
  chk_trig_cause: assert property ($changed(trig_active) |->
      $past(log_strobe) || $past(psel && pwrite) || $past(psel && pwrite, 2))
    else $error("trigger moved without datapoint");

  cov_strobe: cover property (log_strobe);
  cov_trig: cover property ($rose(trig_active));
  cov_err: cover property (pslverr);
endmodule : sil_top_monitor
`default_nettype wire

// ---- testbench/sil_top_tb.sv ----
// Purpose: Self-checking bench of the logger channel
// Assumes: One second shortened to 64 clocks
// Notes:   Outputs read at rising edges, before that edge updates them
`timescale 1ns/1ps
`default_nettype none
module sil_top_tb;
  localparam int unsigned CPS = 64;
  logic        clk_sys = 1'b0;
  logic        rst_b   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  pulse_pin;
  logic        log_strobe;
  logic [15:0] log_data;
  logic        trig_active;
  logic        closed  = 1'b0;
  logic        sel     = 1'b0;
  logic [31:0] rv;
  logic [31:0] dv;
  logic [31:0] dt;
  logic        re;
  int          error_cnt   = 0;
  int          checks_done = 0;

  always #12.5 clk_sys = ~clk_sys;

  sil_top #(.CYC_PER_SEC(CPS)) DUT (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pulse_pin(pulse_pin), .log_strobe(log_strobe),
    .log_data(log_data), .trig_active(trig_active));
  sil_switch_model u_sw (.closed(closed), .sel(sel), .pulse_pin(pulse_pin));

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Request stands until pready is sampled high at a rising edge
    do @(posedge clk_sys); while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic start(input logic [31:0] c, input logic [31:0] p);
    wr(sil_pkg::ADDR_CTRL, 32'h0);
    wr(sil_pkg::ADDR_PERIOD, p);
    sel <= c[1];
    wr(sil_pkg::ADDR_CTRL, c);
  endtask : start

  task automatic settrig(input logic [31:0] k, input logic [31:0] a, input logic [31:0] b,
                         input logic [31:0] h);
    wr(sil_pkg::ADDR_TRIG, 32'h0);
    wr(sil_pkg::ADDR_THR_A, a);
    wr(sil_pkg::ADDR_THR_B, b);
    wr(sil_pkg::ADDR_HYST, h);
    wr(sil_pkg::ADDR_TRIG, k);
  endtask : settrig

  // Waits for a datapoint, then the trigger state one cycle later
  task automatic next_dp();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (log_strobe !== 1'b1 && n < 600);
    check("strobe", {31'h0, log_strobe}, 32'h1);
    dv = {16'h0, log_data};
    @(posedge clk_sys);
    dt = {31'h0, trig_active};
  endtask : next_dp

  task automatic t_regs();
    apb(1'b0, sil_pkg::ADDR_CTRL, 32'h0);
    check("ctrl", rv, sil_pkg::CTRL_RST);
    apb(1'b0, sil_pkg::ADDR_PERIOD, 32'h0);
    check("period", rv, {16'h0, sil_pkg::PERIOD_RST});
    apb(1'b0, sil_pkg::ADDR_TRIG, 32'h0);
    check("trig", rv, sil_pkg::TRIG_RST);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped err", {31'h0, re}, 32'h1);
    check("unmapped data", rv, 32'h0);
  endtask : t_regs

  task automatic t_spot();
    for (int i = 0; i < 4; i++) begin
      closed <= i[0];
      start({26'h0, 1'b0, i[1], 2'b00, i[1], 1'b1}, 32'h1);
      next_dp();
      check("spot", dv, {31'h0, i[0] ^ i[1]});
      apb(1'b0, sil_pkg::ADDR_STATUS, 32'h0);
      check("raw pin", {31'h0, rv[0]}, {31'h0, i[0]});
    end
  endtask : t_spot

  task automatic t_secs();
    settrig(32'h1121, 32'h2, 32'h2, 32'h1);
    closed <= 1'b1;
    start(32'h5, 32'h3);
    next_dp();
    check("secs full", dv, 32'h3);
    apb(1'b0, sil_pkg::ADDR_DATA, 32'h0);
    check("data reg", rv, 32'h3);
    check("window out", dt, 32'h0);
    closed <= 1'b0;
    repeat (80) @(posedge clk_sys);
    closed <= 1'b1;
    next_dp();
    check("secs part", dv, 32'h2);
    check("window in", dt, 32'h1);
    next_dp();
    check("window hyst", dt, 32'h1);
    closed <= 1'b0;
    next_dp();
    check("secs clear", dv, 32'h0);
    check("window clear", dt, 32'h0);
  endtask : t_secs

  task automatic t_trig();
    settrig(32'h1101, 32'h0, 32'h0, 32'h0);
    closed <= 1'b0;
    start(32'h1, 32'h1);
    next_dp();
    check("above idle", dt, 32'h0);
    closed <= 1'b1;
    next_dp();
    check("above rise", dt, 32'h1);
    settrig(32'h1101, 32'h1, 32'h0, 32'h0);
    next_dp();
    check("above one", dt, 32'h0);
    settrig(32'h3201, 32'h0, 32'h0, 32'h0);
    for (int i = 0; i < 3; i++) begin
      closed <= (i != 1);
      next_dp();
      check("c of d", dt, {31'h0, i == 2});
    end
  endtask : t_trig

  task automatic t_frac();
    for (int i = 0; i < 4; i++) begin
      closed <= !i[1];
      start({26'h0, 1'b1, i[0], 4'h1}, 32'h2);
      next_dp();
      check("frac", dv, (i[0] ^ i[1]) ? 32'h0 : 32'h2710);
    end
    settrig(32'h1111, 32'h0, 32'h0, 32'h0);
    closed <= 1'b0;
    start(32'h21, 32'h3);
    next_dp();
    check("below zero", dt, 32'h0);
    settrig(32'h1111, 32'h1d4c, 32'h0, 32'h0);
    repeat (60) @(posedge clk_sys);
    closed <= 1'b1;
    next_dp();
    check("frac part", dv, 32'h1a0a);
    check("below fire", dt, 32'h1);
    settrig(32'h1111, 32'h2711, 32'h0, 32'h0);
    next_dp();
    check("below over range", dt, 32'h1);
  endtask : t_frac

  initial begin
    #(25 * 20000);
    error_cnt++;
    $display("CHECK FAILED watchdog expected end seen hang");
    finish_test();
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_regs();
    t_spot();
    t_secs();
    t_trig();
    t_frac();
    finish_test();
  end
endmodule : sil_top_tb

bind sil_top sil_top_monitor u_mon (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .log_strobe(log_strobe), .log_data(log_data), .trig_active(trig_active));
`default_nettype wire
